// File: design/sps_seq.sv
`timescale 1ns/10ps

// Notes on behaviour
// - 850000 clocks init, then software standby
// - Control bit 2 set starts streaming
// - Streaming returns to standby only after row/frame ends
// - Sudden loss of rails is tolerated
module sps_seq
    import sps_pkg::*;
(
    // Clock and reset (clock stands for the external clock input)
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    // Supply presence levels from outside
    input  wire logic                    pll_supply_on,
    input  wire logic                    analog_supply_on,
    input  wire logic                    pixel_array_supply_on,
    input  wire logic                    io_supply_on,
    input  wire logic                    core_supply_on,
    // Active-low hard reset pin
    input  wire logic                    hard_reset_b,
    // Control register write port
    input  wire logic                    ctrl_wr,
    input  wire logic [SPS_CTRL_W-1:0]   ctrl_wdata,
    // Row/frame boundary from the readout timing
    input  wire logic                    frame_end,
    input  wire logic                    row_end,
    input  wire logic                    stop_at_row,
    // Status
    output logic [SPS_CTRL_W-1:0]        sensor_control_register,
    output logic                         streaming,
    output logic                         sw_standby,
    output logic                         init_busy,
    output logic                         pll_order_fault
);

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    logic [5:0] pins_s;          // Synchronised pin levels
    logic       rails_ok;        // All rails present
    logic       hrst_b_s;        // Synchronised hard reset

    sps_sync2 #(.W(6)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({hard_reset_b, core_supply_on, io_supply_on,
                    pixel_array_supply_on, analog_supply_on,
                    pll_supply_on}),
        .sync_out (pins_s)
    );

    assign hrst_b_s = pins_s[5];
    // Any rail lost drops the device at once, no damage path
    assign rails_ok = &pins_s[4:0];

    // ==========================================================
    // PLL-rail ordering monitor
    // ==========================================================
    // Flags another rail seen without the PLL rail
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pll_order_fault <= 1'b0;
        else if (!(|pins_s[4:0]))
            pll_order_fault <= 1'b0;
        else if (!pins_s[0] && (|pins_s[4:1]))
            pll_order_fault <= 1'b1;
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    sps_state_t           state_q;  // Current state
    sps_state_t           state_d;  // Next state
    logic [SPS_CNT_W-1:0] cnt_q;    // Initialization counter
    logic                 bound;    // Row or frame boundary
    logic                 init_done;

    assign bound     = stop_at_row ? row_end : frame_end;
    assign init_done = (cnt_q == SPS_CNT_W'(SPS_INIT_CYCLES - 1));

    // Next-state decode
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SPS_UNPOWERED:
                // Reset window starts once rails settle
                if (rails_ok)
                    state_d = SPS_HARD_RST;
            SPS_HARD_RST:
                if (hrst_b_s)
                    state_d = SPS_INIT;
            SPS_INIT:
                // Count out initialization
                if (init_done)
                    state_d = SPS_SW_STBY;
            SPS_SW_STBY:
                // Streaming bit starts output
                if (sensor_control_register[SPS_STREAM_BIT])
                    state_d = SPS_STREAM;
            SPS_STREAM:
                if (!sensor_control_register[SPS_STREAM_BIT])
                    state_d = SPS_DRAIN;
            SPS_DRAIN:
                // Stop only at the chosen boundary
                if (bound)
                    state_d = SPS_SW_STBY;
                else if (sensor_control_register[SPS_STREAM_BIT])
                    state_d = SPS_STREAM;
            default:
                state_d = SPS_UNPOWERED;
        endcase
        // Rail loss or hard reset override everything
        if (!rails_ok)
            state_d = SPS_UNPOWERED;
        else if (!hrst_b_s && state_q != SPS_UNPOWERED)
            state_d = SPS_HARD_RST;
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= SPS_UNPOWERED;
        else
            state_q <= state_d;
    end

    // Initialization counter, only runs in init
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= SPS_CNT_ZERO;
        else if (state_q == SPS_INIT && state_d == SPS_INIT)
            cnt_q <= cnt_q + SPS_CNT_ONE;
        else
            cnt_q <= SPS_CNT_ZERO;
    end

    // ==========================================================
    // Control register
    // ==========================================================
    // Writable only in standby, streaming or drain; cleared by reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sensor_control_register <= SPS_CTRL_RESET;
        else if (state_q == SPS_UNPOWERED || state_q == SPS_HARD_RST
                 || state_q == SPS_INIT)
            sensor_control_register <= SPS_CTRL_RESET;
        else if (ctrl_wr)
            sensor_control_register <= ctrl_wdata;
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            streaming  <= 1'b0;
            sw_standby <= 1'b0;
            init_busy  <= 1'b0;
        end
        else
        begin
            streaming  <= (state_d == SPS_STREAM) ||
                          (state_d == SPS_DRAIN);
            sw_standby <= (state_d == SPS_SW_STBY);
            init_busy  <= (state_d == SPS_INIT);
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Init must not end before the full count has run out
    property p_init_len;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_INIT && !init_done && rails_ok && hrst_b_s)
        |=> (state_q == SPS_INIT) && init_busy && !sw_standby;
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("standby reached before init count");

    property p_init_end;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_INIT && init_done && rails_ok && hrst_b_s)
        |=> (state_q == SPS_SW_STBY) ##0 sw_standby;
    endproperty
    a_init_end: assert property (p_init_end)
        else $error("init end did not give standby");

    property p_stream_go;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_SW_STBY
         && sensor_control_register[SPS_STREAM_BIT]
         && rails_ok && hrst_b_s) |=> streaming;
    endproperty
    a_stream_go: assert property (p_stream_go)
        else $error("streaming bit ignored");

    property p_drain_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_DRAIN && !bound && rails_ok && hrst_b_s)
        |=> !sw_standby;
    endproperty
    a_drain_hold: assert property (p_drain_hold)
        else $error("standby before boundary");

    property p_drain_end;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_DRAIN && bound && rails_ok && hrst_b_s)
        |=> sw_standby && !streaming;
    endproperty
    a_drain_end: assert property (p_drain_end)
        else $error("boundary did not give standby");

    property p_rail_loss;
        @(posedge core_clk) disable iff (!rst_b)
        !rails_ok |=> (state_q == SPS_UNPOWERED) && !streaming;
    endproperty
    a_rail_loss: assert property (p_rail_loss)
        else $error("rail loss not handled");

    property p_pll_order;
        @(posedge core_clk) disable iff (!rst_b)
        (!pins_s[0] && $rose(|pins_s[4:1])) |=> pll_order_fault;
    endproperty
    a_pll_order: assert property (p_pll_order)
        else $error("pll ordering fault missed");

    property p_rst_wait;
        @(posedge core_clk) disable iff (!rst_b)
        (state_q == SPS_HARD_RST && !hrst_b_s) |=> !init_busy;
    endproperty
    a_rst_wait: assert property (p_rst_wait)
        else $error("init began under hard reset");

    c_init:   cover property (@(posedge core_clk) disable iff (!rst_b)
                  $rose(sw_standby));
    c_stream: cover property (@(posedge core_clk) disable iff (!rst_b)
                  $rose(streaming));
    c_drain:  cover property (@(posedge core_clk) disable iff (!rst_b)
                  state_q == SPS_DRAIN ##1 state_q == SPS_SW_STBY);

endmodule // sps_seq

// File: design/sps_pkg.sv
package sps_pkg;

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [5:0] {
        SPS_UNPOWERED = 6'b00_0001,  // Rails not all present
        SPS_HARD_RST  = 6'b00_0010,  // Held in hard reset
        SPS_INIT      = 6'b00_0100,  // Internal initialization count
        SPS_SW_STBY   = 6'b00_1000,  // Software standby
        SPS_STREAM    = 6'b01_0000,  // Streaming frames
        SPS_DRAIN     = 6'b10_0000   // Finishing row or frame
    } sps_state_t;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned SPS_INIT_CYCLES   = 850000;  // Init clocks
    localparam int unsigned SPS_CNT_W         = 20;      // Counter width
    localparam int unsigned SPS_CTRL_W        = 16;      // Control width
    localparam int unsigned SPS_STREAM_BIT    = 2;       // Streaming field
    localparam logic [15:0] SPS_CTRL_RESET    = 16'h0000;// Control reset
    localparam logic [19:0] SPS_CNT_ZERO      = 20'h0_0000;
    localparam logic [19:0] SPS_CNT_ONE       = 20'h0_0001;

endpackage

// File: design/sps_sync2.sv
`timescale 1ns/10ps

// ==============================================================
// Two-flop synchroniser for a bundle of levels
// ==============================================================
module sps_sync2 #(
    parameter int unsigned W = 1  // Bundle width
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;  // First stage, read only by second

    // Two stages, cleared on reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sps_sync2

// File: tb/sps_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// Host side model: supply rails and hard reset pin
// ==========================================================
module sps_host_model #(
    parameter int unsigned RST_HOLD = 200,  // Reset width, scaled down
    parameter int unsigned OFF_HOLD = 400   // Rails-off time, scaled
) (
    // Clock
    input  wire logic core_clk,
    // Rails and reset pin
    output logic      pll_on,
    output logic      ana_on,
    output logic      pix_on,
    output logic      io_on,
    output logic      core_on,
    output logic      hard_reset_b
);
    // Everything off at time zero
    initial {pll_on, ana_on, pix_on, io_on, core_on, hard_reset_b} = 6'h00;

    // Gap of 0 to 7 cycles between rail steps
    task automatic gap(input logic [2:0] n);
        repeat (n) @(negedge core_clk);
    endtask

    // Ordered power-up, reset held, then released
    task automatic power_up(input logic [8:0] r);
        @(negedge core_clk);
        pll_on = 1'b1;
        gap(r[2:0]);
        ana_on = 1'b1;
        pix_on = 1'b1;
        gap(r[5:3]);
        io_on = 1'b1;
        gap(r[8:6]);
        core_on = 1'b1;
        repeat (RST_HOLD) @(negedge core_clk);
        hard_reset_b = 1'b1;
    endtask

    // Ordered power-down, rails then held off
    task automatic power_down();
        @(negedge core_clk);
        core_on = 1'b0;
        @(negedge core_clk);
        io_on = 1'b0;
        @(negedge core_clk);
        ana_on = 1'b0;
        pix_on = 1'b0;
        @(negedge core_clk);
        pll_on = 1'b0;
        hard_reset_b = 1'b0;
        repeat (OFF_HOLD) @(negedge core_clk);
    endtask

    // Faulty host: analog rail before the pll rail
    task automatic late_pll();
        @(negedge core_clk);
        ana_on = 1'b1;
        repeat (4) @(negedge core_clk);
        pll_on = 1'b1;
    endtask

    // Every rail lost at once
    task automatic drop_all();
        @(negedge core_clk);
        {pll_on, ana_on, pix_on, io_on, core_on} = 5'h00;
    endtask
endmodule // sps_host_model

// File: tb/sps_seq_test.sv
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the power sequencer
// ==========================================================
module sps_seq_test;
    import sps_pkg::*;

    logic        core_clk = 1'b0;  // Device clock
    logic        rst_b    = 1'b0;  // Logic reset
    logic        pll_on, ana_on, pix_on, io_on, core_on, hard_reset_b;
    logic        ctrl_wr, frame_end, row_end, stop_at_row;
    logic [15:0] ctrl_wdata;       // Control write data
    logic [15:0] ctrl_reg;         // Control register view
    logic        streaming, sw_standby, init_busy, pll_order_fault;
    logic [19:0] exp_q[$];         // Expected output changes
    logic [19:0] last_obs;         // Outputs at previous edge
    logic        watch    = 1'b0;  // Monitor enable
    logic [31:0] seed     = 32'h0000_3c23;
    int          miscompares  = 0;
    int          total_checks = 0;
    wire  [19:0] obs = {ctrl_reg, streaming, sw_standby, init_busy,
                        pll_order_fault};

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    sps_host_model u_host (.core_clk(core_clk), .pll_on(pll_on),
        .ana_on(ana_on), .pix_on(pix_on), .io_on(io_on),
        .core_on(core_on), .hard_reset_b(hard_reset_b));

    sps_seq u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .pll_supply_on(pll_on), .analog_supply_on(ana_on),
        .pixel_array_supply_on(pix_on), .io_supply_on(io_on),
        .core_supply_on(core_on), .hard_reset_b(hard_reset_b),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .frame_end(frame_end), .row_end(row_end),
        .stop_at_row(stop_at_row), .sensor_control_register(ctrl_reg),
        .streaming(streaming), .sw_standby(sw_standby),
        .init_busy(init_busy), .pll_order_fault(pll_order_fault));

    // Random source
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Compare and count
    task automatic chk(input logic [19:0] got, exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    // Each output change takes the oldest note; looked at on the
    // falling edge, where the registered outputs have settled
    always @(negedge core_clk)
    begin
        if (watch && obs !== last_obs)
        begin
            if (exp_q.size() == 0)
                chk(obs, ~obs, "unexpected change");
            else
                chk(obs, exp_q.pop_front(), "output change");
        end
        last_obs <= obs;
    end

    // Note an expected output change
    task automatic note(input logic [15:0] r, input logic [3:0] f);
        exp_q.push_back({r, f});
    endtask

    // Control write; hold keeps the strobe for a back-to-back write
    task automatic wr(input logic [15:0] d, input bit hold);
        @(negedge core_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        if (!hold)
        begin
            @(negedge core_clk);
            ctrl_wr = 1'b0;
        end
    endtask

    // Row or frame boundary pulse
    task automatic pulse(input bit row);
        @(negedge core_clk);
        if (row)
            row_end = 1'b1;
        else
            frame_end = 1'b1;
        @(negedge core_clk);
        {row_end, frame_end} = 2'b00;
        repeat (3) @(negedge core_clk);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #4_600_000;
        miscompares++;
        $display("wrong value at %0t: timeout", $time);
        wrap_up();
    end

    // Main sequence
    initial
    begin
        int          n;
        int          k;
        logic [31:0] r;
        logic [15:0] v;
        {ctrl_wr, frame_end, row_end, stop_at_row} = 4'h0;
        ctrl_wdata = 16'h0004;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        watch = 1'b1;
        note(16'h0000, 4'b0010);
        note(16'h0000, 4'b0100);
        r = xorshift();
        u_host.power_up(r[8:0]);
        n = 0;
        k = 0;
        while (!sw_standby && k < 900_000)
        begin
            @(negedge core_clk);
            ctrl_wr = (n == 100);  // Write during init is dropped
            n = n + int'(init_busy);
            k++;
        end
        chk(20'(n >= 850_000 && n <= 850_001), 20'h0_0001, "init");
        $display("test init done");
        for (int m = 0; m < 2; m++)
        begin
            stop_at_row = m[0];
            // Lock wait after configuration, scaled down
            repeat (20) @(negedge core_clk);
            r = xorshift();
            v = r[15:0] | 16'h0004;
            // Second write lands on the edge that starts streaming
            note(v, 4'b0100);
            wr(v, 1);
            v = v ^ ((r[31:16] & 16'hfffb) | 16'h0001);
            note(v, 4'b1000);
            wr(v, 0);
            pulse(m[0]);
            v = v & 16'hfffb;
            note(v, 4'b1000);
            wr(v, 0);
            if (m == 0)
                pulse(1'b1);
            else
            begin
                note(v | 16'h0004, 4'b1000);
                wr(v | 16'h0004, 0);
                note(v, 4'b1000);
                wr(v, 0);
                pulse(1'b0);
            end
            note(v, 4'b0100);
            pulse(m[0]);
            $display("test stream mode %0d done", m);
        end
        chk(20'(exp_q.size()), 20'h0_0000, "notes left");
        watch = 1'b0;
        u_host.power_down();
        chk(obs, 20'h0_0000, "power down");
        u_host.late_pll();
        repeat (4) @(negedge core_clk);
        chk(obs, 20'h0_0001, "late pll rail");
        u_host.drop_all();
        repeat (4) @(negedge core_clk);
        chk(obs, 20'h0_0000, "sudden loss");
        $display("test power down done");
        wrap_up();
    end
endmodule // sps_seq_test
